//--- verilog/mfx_fifo_dev.sv
// Purpose: FIFO device end with almost flags, two mailboxes and replay
// Assumes: Both ports share clk; the host keeps its own access rules
// Notes:   Flags are registered; full and empty change on the causing edge, almost flags one cycle after it
`timescale 1ns/1ps
// What this block does
// - Writer selects A low, direction high, box low
// - Reader selects B low, direction high, box low
// - Depth parameter sets full and almost-full thresholds
// - Almost-full rises next cycle after leaving range
// - Narrow B: almost-full timed from final part
// - Narrow B: almost-empty falls next cycle after final part
// - Almost-empty rises next cycle after write
// - Word B: A-to-B mailbox carries bits 0-17
// - Byte B: A-to-B mailbox carries bits 0-8
// - Word B: B-to-A mailbox carries bits 0-17
// - Byte B: B-to-A mailbox carries bits 0-8
// - Replay only in standard mode, clocks running
// - Writer pauses around replay and recovery
// - Full and empty valid after recovery
// - Almost flags update two cycles after recovery
// - Writer keeps fill at or below depth minus margin while replay is armed
module mfx_fifo_dev #(
   parameter int unsigned DEPTH    = mfx_pkg::DEPTH_1K,
   parameter int unsigned AF_OFFSET = mfx_pkg::FLAG_OFFSET,
   parameter int unsigned AE_OFFSET = mfx_pkg::FLAG_OFFSET
)(
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire mfx_pkg::mfx_size_t bus_size,
   input  wire logic              fall_through_mode,
   output logic                   replay_busy,
   mfx_if.dev                     pins
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [35:0]  mem [DEPTH];                      // Long-word store
   logic [AW:0]  wp_q;
   logic [AW:0]  rp_q;
   logic [1:0]   part_q;                            // Part of long-word being read
   logic [35:0]  a_to_b_mailbox;
   logic [35:0]  b_to_a_mailbox;
   logic [35:0]  b_out_q;
   logic [35:0]  a_out_q;
   logic         b_oe_q;
   logic         a_oe_q;
   logic         full_n_q;
   logic         empty_n_q;
   logic         af_n_q;
   logic         ae_n_q;
   logic         ab_full_n_q;
   logic         ba_full_n_q;
   logic         replay_q;
   logic [2:0]   settle_q;                          // Recovery plus settle countdown
   logic [AW:0]  count;
   logic [AW:0]  count_nx;                          // Fill after this edge's transfers
   logic         wr_fifo;
   logic         rd_fifo;
   logic         rd_last;
   logic         wr_box_a;
   logic         rd_box_b;
   logic         wr_box_b;
   logic         rd_box_a;
   logic         replay_go;

   // Port strobes decoded from the select pins
   assign wr_fifo  = !pins.port_a_select_n && pins.port_a_direction
                     && !pins.port_a_box_select && full_n_q;
   assign rd_fifo  = !pins.port_b_select_n && pins.port_b_direction
                     && !pins.port_b_box_select && empty_n_q;
   assign rd_last  = rd_fifo && (part_q == mfx_pkg::mfx_last_part(bus_size));
   assign wr_box_a = !pins.port_a_select_n && pins.port_a_direction
                     && pins.port_a_box_select;
   assign rd_box_a = !pins.port_a_select_n && !pins.port_a_direction
                     && pins.port_a_box_select;
   assign wr_box_b = !pins.port_b_select_n && !pins.port_b_direction
                     && pins.port_b_box_select;
   assign rd_box_b = !pins.port_b_select_n && pins.port_b_direction
                     && pins.port_b_box_select;
   assign replay_go = !pins.replay_request_n && !fall_through_mode;
   assign count     = wp_q - rp_q;
   // Full and empty take the post-edge fill, else a back-to-back read overruns empty
   assign count_nx  = wp_q + (AW+1)'(wr_fifo) - (replay_go ? '0 : rp_q + (AW+1)'(rd_last));

   // Memory write; no reset so it maps onto a RAM
   always_ff @(posedge clk)
   begin
      if (wr_fifo)
      begin
         mem[wp_q[AW-1:0]] <= pins.a_dq_host;
      end
   end

   // Write pointer is untouched by replay
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         wp_q <= '0;
      end
      else if (wr_fifo)
      begin
         wp_q <= wp_q + 1'b1;
      end
   end

   // Read pointer advances only on the final part of a long-word
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rp_q   <= '0;
         part_q <= 2'h0;
      end
      else if (replay_go)
      begin
         rp_q   <= '0;
         part_q <= 2'h0;
      end
      else if (rd_fifo)
      begin
         part_q <= rd_last ? 2'h0 : part_q + 2'h1;
         if (rd_last)
         begin
            rp_q <= rp_q + 1'b1;
         end
      end
   end

   // Port B output: FIFO part or mailbox, narrow parts zero-filled
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         b_out_q <= 36'h0;
         b_oe_q  <= 1'b0;
      end
      else
      begin
         b_oe_q <= !pins.port_b_select_n && pins.port_b_direction;
         if (rd_box_b)
         begin
            b_out_q <= mfx_pkg::mfx_mask(a_to_b_mailbox, bus_size);
         end
         else if (rd_fifo)
         begin
            unique case (bus_size)
               mfx_pkg::MFX_SIZE_WORD:
                  b_out_q <= mfx_pkg::mfx_mask(
                     mem[rp_q[AW-1:0]] >> (part_q[0] * 18), bus_size);
               mfx_pkg::MFX_SIZE_BYTE:
                  b_out_q <= mfx_pkg::mfx_mask(
                     mem[rp_q[AW-1:0]] >> (part_q * 9), bus_size);
               default:
                  b_out_q <= mem[rp_q[AW-1:0]];
            endcase
         end
      end
   end

   // A-to-B mailbox: write on A sets busy, read on B frees it
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         a_to_b_mailbox <= 36'h0;
         ab_full_n_q    <= 1'b1;
      end
      else
      begin
         if (wr_box_a && ab_full_n_q)
         begin
            a_to_b_mailbox <= mfx_pkg::mfx_mask(pins.a_dq_host, bus_size);
         end
         // New mail wins over a read in the same cycle
         if (wr_box_a && ab_full_n_q)
         begin
            ab_full_n_q <= 1'b0;
         end
         else if (rd_box_b)
         begin
            ab_full_n_q <= 1'b1;
         end
      end
   end

   // B-to-A mailbox, same scheme in the other direction
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         b_to_a_mailbox <= 36'h0;
         ba_full_n_q    <= 1'b1;
      end
      else
      begin
         if (wr_box_b && ba_full_n_q)
         begin
            b_to_a_mailbox <= mfx_pkg::mfx_mask(pins.b_dq_host, bus_size);
         end
         if (wr_box_b && ba_full_n_q)
         begin
            ba_full_n_q <= 1'b0;
         end
         else if (rd_box_a)
         begin
            ba_full_n_q <= 1'b1;
         end
      end
   end

   // Port A drives only the B-to-A mailbox
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         a_out_q <= 36'h0;
         a_oe_q  <= 1'b0;
      end
      else
      begin
         a_oe_q <= !pins.port_a_select_n && !pins.port_a_direction;
         if (rd_box_a)
         begin
            a_out_q <= b_to_a_mailbox;
         end
      end
   end

   // Replay window: low request, then recovery, then almost-flag settle
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         replay_q <= 1'b0;
         settle_q <= 3'h0;
      end
      else if (replay_go)
      begin
         replay_q <= 1'b1;
         settle_q <= 3'(mfx_pkg::RECOVERY_CYC + mfx_pkg::ALMOST_SETTLE_CYC);
      end
      else if (settle_q != 3'h0)
      begin
         settle_q <= settle_q - 3'h1;
      end
      else
      begin
         replay_q <= 1'b0;
      end
   end

   // Full and empty follow the pointers even while replay runs
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         full_n_q  <= 1'b0;
         empty_n_q <= 1'b0;
      end
      else
      begin
         full_n_q  <= count_nx < (AW+1)'(DEPTH);
         empty_n_q <= count_nx != '0;
      end
   end

   // Almost flags frozen until the settle time is over; almost-full threshold from depth, almost-empty from AE_OFFSET
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         af_n_q <= 1'b1;
         ae_n_q <= 1'b0;
      end
      else if (!replay_q)
      begin
         af_n_q <= count <= (AW+1)'(DEPTH - AF_OFFSET);
         ae_n_q <= count > (AW+1)'(AE_OFFSET);
      end
   end

   assign pins.full_n             = full_n_q;
   assign pins.empty_n            = empty_n_q;
   assign pins.almost_full_n      = af_n_q;
   assign pins.almost_empty_n     = ae_n_q;
   assign pins.a_to_b_mail_full_n = ab_full_n_q;
   assign pins.b_to_a_mail_full_n = ba_full_n_q;
   assign pins.b_dq_dev           = b_out_q;
   assign pins.b_dq_dev_oe        = b_oe_q;
   assign pins.a_dq_dev           = a_out_q;
   assign pins.a_dq_dev_oe        = a_oe_q;
   assign replay_busy             = replay_q;
endmodule : mfx_fifo_dev

//--- verilog/mfx_pkg.sv
// Purpose: Shared constants and types for the flag, mailbox and replay FIFO pair
// Assumes: Both ends run on one 20 MHz clock
// Notes:   Port B width selects how a long-word is split on reads and mail
package mfx_pkg;
   localparam int unsigned LW_BITS      = 36;               // Long-word width
   localparam int unsigned WORD_BITS    = 18;               // Port B word width
   localparam int unsigned BYTE_BITS    = 9;                // Port B byte width
   localparam int unsigned DEPTH_1K     = 1024;             // Smallest depth option
   localparam int unsigned DEPTH_4K     = 4096;
   localparam int unsigned DEPTH_16K    = 16384;
   localparam int unsigned FLAG_OFFSET  = 8;                // Default almost-flag offset
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned RECOVERY_NS  = 90;               // Replay recovery time
   localparam int unsigned RECOVERY_CYC =
      (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;   // Least time, rounded up
   localparam int unsigned ALMOST_SETTLE_CYC = 2;           // Extra cycles for almost flags
   localparam int unsigned REPLAY_LOW_CYC = 1;              // Replay request pulse width
   localparam int unsigned MARGIN_LONG  = 2;                // Replay headroom per width
   localparam int unsigned MARGIN_WORD  = 4;
   localparam int unsigned MARGIN_BYTE  = 8;

   typedef enum logic [1:0]
   {
      MFX_SIZE_LONG = 2'h0,
      MFX_SIZE_WORD = 2'h1,
      MFX_SIZE_BYTE = 2'h2
   } mfx_size_t;

   // Keeps only the bits that the current port B width carries
   function automatic logic [LW_BITS-1:0] mfx_mask(input logic [LW_BITS-1:0] v,
                                                   input mfx_size_t           s);
      logic [LW_BITS-1:0] m;
      m = v;
      if (s == MFX_SIZE_WORD)
      begin
         m = {{(LW_BITS-WORD_BITS){1'b0}}, v[WORD_BITS-1:0]};
      end
      else if (s == MFX_SIZE_BYTE)
      begin
         m = {{(LW_BITS-BYTE_BITS){1'b0}}, v[BYTE_BITS-1:0]};
      end
      return m;
   endfunction : mfx_mask

   // Number of port B transfers per long-word, less one
   function automatic logic [1:0] mfx_last_part(input mfx_size_t s);
      logic [1:0] p;
      p = 2'h0;
      if (s == MFX_SIZE_WORD)
      begin
         p = 2'h1;
      end
      else if (s == MFX_SIZE_BYTE)
      begin
         p = 2'h3;
      end
      return p;
   endfunction : mfx_last_part
endpackage : mfx_pkg

//--- verilog/mfx_if.sv
// Purpose: Pin bundle joining the FIFO device end and its host end
// Assumes: Data pins are split into in, out and enable per driver
// Notes:   Each end reads the other's data pins directly; no shared wire level is resolved
`timescale 1ns/1ps
interface mfx_if;
   logic        port_a_select_n;
   logic        port_a_direction;
   logic        port_a_box_select;
   logic        port_b_select_n;
   logic        port_b_direction;
   logic        port_b_box_select;
   logic        replay_request_n;
   logic [35:0] a_dq_host;
   logic        a_dq_host_oe;
   logic [35:0] a_dq_dev;
   logic        a_dq_dev_oe;
   logic [35:0] b_dq_host;
   logic        b_dq_host_oe;
   logic [35:0] b_dq_dev;
   logic        b_dq_dev_oe;
   logic        full_n;
   logic        empty_n;
   logic        almost_full_n;
   logic        almost_empty_n;
   logic        a_to_b_mail_full_n;
   logic        b_to_a_mail_full_n;

   modport dev
   (
      input  port_a_select_n, port_a_direction, port_a_box_select,
      input  port_b_select_n, port_b_direction, port_b_box_select,
      input  replay_request_n, a_dq_host, a_dq_host_oe, b_dq_host, b_dq_host_oe,
      output a_dq_dev, a_dq_dev_oe, b_dq_dev, b_dq_dev_oe,
      output full_n, empty_n, almost_full_n, almost_empty_n,
      output a_to_b_mail_full_n, b_to_a_mail_full_n
   );

   modport host
   (
      output port_a_select_n, port_a_direction, port_a_box_select,
      output port_b_select_n, port_b_direction, port_b_box_select,
      output replay_request_n, a_dq_host, a_dq_host_oe, b_dq_host, b_dq_host_oe,
      input  a_dq_dev, a_dq_dev_oe, b_dq_dev, b_dq_dev_oe,
      input  full_n, empty_n, almost_full_n, almost_empty_n,
      input  a_to_b_mail_full_n, b_to_a_mail_full_n
   );
endinterface : mfx_if

//--- verilog/mfx_fifo_host.sv
// Purpose: Host end that writes port A from a buffer and reads port B
// Assumes: Device flags are registered and valid one cycle after a change
// Notes:   Writes pause around replay; fill is capped while replay is armed
`timescale 1ns/1ps
module mfx_buf #(
   parameter int unsigned WIDTH = 36,
   parameter int unsigned DEPTH = 32
)(
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wp_q;
   logic [AW:0]      rp_q;

   assign in_ready  = (wp_q - rp_q) != (AW+1)'(DEPTH);
   assign out_valid = wp_q != rp_q;
   assign out_data  = mem[rp_q[AW-1:0]];

   // Storage has no reset; only pointers need one
   always_ff @(posedge clk)
   begin
      if (in_valid && in_ready)
      begin
         mem[wp_q[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         wp_q <= '0;
         rp_q <= '0;
      end
      else
      begin
         if (in_valid && in_ready)
         begin
            wp_q <= wp_q + 1'b1;
         end
         if (out_valid && out_ready)
         begin
            rp_q <= rp_q + 1'b1;
         end
      end
   end
endmodule : mfx_buf

module mfx_fifo_host #(
   parameter int unsigned DEPTH = mfx_pkg::DEPTH_1K
)(
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire mfx_pkg::mfx_size_t bus_size,
   input  wire logic [35:0]       wr_data,
   input  wire logic              wr_valid,
   output logic                   wr_ready,
   input  wire logic              rd_enable,
   output logic [35:0]            rd_data,
   output logic                   rd_valid,
   input  wire logic              replay_arm,
   input  wire logic              replay_start,
   output logic                   replay_done,
   mfx_if.host                    pins
);
   typedef enum logic [1:0]
   {
      MFX_H_RUN   = 2'h0,
      MFX_H_PAUSE = 2'h1,
      MFX_H_LOW   = 2'h2,
      MFX_H_WAIT  = 2'h3
   } mfx_host_st_t;

   mfx_host_st_t st_q;
   logic [35:0]  buf_data;
   logic         buf_valid;
   logic         take;
   logic [15:0]  written_q;
   logic [15:0]  limit;
   logic [2:0]   wait_q;
   logic         a_sel_n_q;
   logic [35:0]  a_dq_q;
   logic         b_sel_n_q;
   logic         rd_pend_q;
   logic [35:0]  rd_data_q;
   logic         rd_valid_q;
   logic         done_q;

   // Headroom that keeps a replay safe for the current width
   always_comb
   begin
      unique case (bus_size)
         mfx_pkg::MFX_SIZE_WORD: limit = 16'(DEPTH - mfx_pkg::MARGIN_WORD);
         mfx_pkg::MFX_SIZE_BYTE: limit = 16'(DEPTH - mfx_pkg::MARGIN_BYTE);
         default:                limit = 16'(DEPTH - mfx_pkg::MARGIN_LONG);
      endcase
   end

   // Stall draining when full, paused, or the replay cap is reached
   // Near full, wait for the write in flight: full_n cannot see it yet
   assign take = buf_valid && pins.full_n && (a_sel_n_q || pins.almost_full_n)
                 && st_q == MFX_H_RUN && !replay_start
                 && !(replay_arm && written_q >= limit);

   mfx_buf #(.WIDTH(36), .DEPTH(32)) u_buf
   (
      .clk       (clk),
      .resetn    (resetn),
      .in_data   (wr_data),
      .in_valid  (wr_valid),
      .in_ready  (wr_ready),
      .out_data  (buf_data),
      .out_valid (buf_valid),
      .out_ready (take)
   );

   // Port A write issue
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         a_sel_n_q <= 1'b1;
         a_dq_q    <= 36'h0;
         written_q <= 16'h0;
      end
      else
      begin
         a_sel_n_q <= !take;
         if (take)
         begin
            a_dq_q    <= buf_data;
            written_q <= written_q + 16'h1;
         end
      end
   end

   // Replay sequence: one idle write cycle, low pulse, recovery wait
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         st_q   <= MFX_H_RUN;
         wait_q <= 3'h0;
         done_q <= 1'b0;
      end
      else
      begin
         done_q <= 1'b0;
         unique case (st_q)
            MFX_H_RUN:
               if (replay_start)
               begin
                  st_q <= MFX_H_PAUSE;
               end
            MFX_H_PAUSE:
               st_q <= MFX_H_LOW;
            MFX_H_LOW:
            begin
               st_q   <= MFX_H_WAIT;
               wait_q <= 3'(mfx_pkg::RECOVERY_CYC + mfx_pkg::ALMOST_SETTLE_CYC);
            end
            MFX_H_WAIT:
               if (wait_q == 3'h0)
               begin
                  st_q   <= MFX_H_RUN;
                  done_q <= 1'b1;
               end
               else
               begin
                  wait_q <= wait_q - 3'h1;
               end
         endcase
      end
   end

   // Port B read issue and capture one cycle later
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         b_sel_n_q  <= 1'b1;
         rd_pend_q  <= 1'b0;
         rd_data_q  <= 36'h0;
         rd_valid_q <= 1'b0;
      end
      else
      begin
         b_sel_n_q  <= !(rd_enable && pins.empty_n && st_q == MFX_H_RUN);
         rd_pend_q  <= !b_sel_n_q && pins.empty_n;
         rd_valid_q <= rd_pend_q;
         if (rd_pend_q)
         begin
            rd_data_q <= pins.b_dq_dev;
         end
      end
   end

   assign pins.port_a_select_n   = a_sel_n_q;
   assign pins.port_a_direction  = 1'b1;
   assign pins.port_a_box_select = 1'b0;
   assign pins.a_dq_host         = a_dq_q;
   assign pins.a_dq_host_oe      = 1'b1;
   assign pins.port_b_select_n   = b_sel_n_q;
   assign pins.port_b_direction  = 1'b1;
   assign pins.port_b_box_select = 1'b0;
   assign pins.b_dq_host         = 36'h0;
   assign pins.b_dq_host_oe      = 1'b0;
   assign pins.replay_request_n  = st_q != MFX_H_LOW;
   assign rd_data                = rd_data_q;
   assign rd_valid               = rd_valid_q;
   assign replay_done            = done_q;
endmodule : mfx_fifo_host

//--- verification/mfx_props.sv
// Purpose: Concurrent checks on the pin bundle between the FIFO ends
// Assumes: One clock; device flags are registered
// Notes:   Sees only interface signals, so replay state is inferred
`timescale 1ns/1ps
module mfx_props (
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        port_a_select_n,
   input wire logic        port_a_direction,
   input wire logic        port_a_box_select,
   input wire logic        port_b_select_n,
   input wire logic        port_b_direction,
   input wire logic        port_b_box_select,
   input wire logic        replay_request_n,
   input wire logic        b_dq_dev_oe,
   input wire logic        full_n,
   input wire logic        empty_n,
   input wire logic        almost_full_n,
   input wire logic        almost_empty_n
);
   logic wr;
   logic rd;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   // Decoded FIFO strobes, the read only counts when data is there
   assign wr = !port_a_select_n && port_a_direction && !port_a_box_select;
   assign rd = !port_b_select_n && port_b_direction && !port_b_box_select && empty_n;

   AST_RD_DRIVE: assert property (rd |=> b_dq_dev_oe)
      else $error("read data not driven");
   AST_WR_FILL: assert property (wr && !empty_n && replay_request_n |-> ##[1:2] empty_n)
      else $error("empty flag stuck after write");
   AST_EMPTY_AE: assert property (!empty_n |-> !almost_empty_n)
      else $error("almost empty high while empty");
   AST_FULL_AF: assert property (!full_n && $past(resetn) |-> !almost_full_n)
      else $error("almost full high while full");
   AST_NO_WR_RT: assert property (!replay_request_n |-> port_a_select_n)
      else $error("write during replay");
   AST_PRE_RT: assert property ($fell(replay_request_n) |-> $past(port_a_select_n))
      else $error("write just before replay");
   AST_POST_RT: assert property ($rose(replay_request_n) |-> port_a_select_n [*2])
      else $error("write inside recovery");
   AST_AE_FREEZE: assert property ($fell(replay_request_n) |=> $stable(almost_empty_n) [*2])
      else $error("almost empty moved during replay");

   CV_WR: cover property (wr);
   CV_RD: cover property (rd);
   CV_RT: cover property ($fell(replay_request_n));
endmodule : mfx_props

//--- verification/test_fifo_flag_mailbox_retransmit.sv
// Purpose: Random traffic, flag, replay and fill tests of the FIFO pair
// Assumes: Host end reads until empty and returns one port B part per read
// Notes:   Every read drains the FIFO, so no read is left in flight
`timescale 1ns/1ps
module test_fifo_flag_mailbox_retransmit;
   logic               clk = 1'b0;
   logic               resetn;
   mfx_pkg::mfx_size_t bus_size;
   logic [35:0]        wr_data;
   logic               wr_valid;
   logic               wr_ready;
   logic               rd_enable;
   logic [35:0]        rd_data;
   logic               rd_valid;
   logic               replay_arm;
   logic               replay_start;
   logic               replay_done;
   logic               replay_busy;
   logic [35:0]        q[$];
   logic [35:0]        hist[$];
   int                 seed = 32'hE575E9EB;
   int                 n_mismatch = 0;
   int                 n_checks = 0;
   mfx_pkg::mfx_size_t sizes[3] = '{mfx_pkg::MFX_SIZE_LONG, mfx_pkg::MFX_SIZE_WORD,
                                    mfx_pkg::MFX_SIZE_BYTE};

   mfx_if mfx_if_i ();
   mfx_fifo_dev #(.DEPTH(mfx_pkg::DEPTH_1K)) mfx_fifo_dev_i (.clk(clk), .resetn(resetn),
      .bus_size(bus_size), .fall_through_mode(1'b0), .replay_busy(replay_busy),
      .pins(mfx_if_i));
   mfx_fifo_host #(.DEPTH(mfx_pkg::DEPTH_1K)) mfx_fifo_host_i (.clk(clk), .resetn(resetn),
      .bus_size(bus_size), .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
      .rd_enable(rd_enable), .rd_data(rd_data), .rd_valid(rd_valid),
      .replay_arm(replay_arm), .replay_start(replay_start), .replay_done(replay_done),
      .pins(mfx_if_i));
   mfx_props mfx_props_i (.clk(clk), .resetn(resetn),
      .port_a_select_n(mfx_if_i.port_a_select_n), .port_a_direction(mfx_if_i.port_a_direction),
      .port_a_box_select(mfx_if_i.port_a_box_select),
      .port_b_select_n(mfx_if_i.port_b_select_n), .port_b_direction(mfx_if_i.port_b_direction),
      .port_b_box_select(mfx_if_i.port_b_box_select),
      .replay_request_n(mfx_if_i.replay_request_n), .b_dq_dev_oe(mfx_if_i.b_dq_dev_oe),
      .full_n(mfx_if_i.full_n), .empty_n(mfx_if_i.empty_n),
      .almost_full_n(mfx_if_i.almost_full_n), .almost_empty_n(mfx_if_i.almost_empty_n));

   // Free-running 20 MHz clock
   always #25 clk = ~clk;

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : print_verdict

   task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Port B part width for the current size
   function automatic int part_w();
      if (bus_size == mfx_pkg::MFX_SIZE_WORD)
         return mfx_pkg::WORD_BITS;
      if (bus_size == mfx_pkg::MFX_SIZE_BYTE)
         return mfx_pkg::BYTE_BITS;
      return mfx_pkg::LW_BITS;
   endfunction : part_w

   // A wait that ran out ends the run as a mismatch
   task automatic guard(input int t);
      if (t >= 4000)
      begin
         n_mismatch++;
         print_verdict();
      end
   endtask : guard

   task automatic do_reset;
      @(negedge clk);
      resetn = 1'b0;
      repeat (8) @(negedge clk);
      resetn = 1'b1;
      q.delete();
      hist.delete();
      repeat (2) @(negedge clk);
   endtask : do_reset

   // Offer n random long-words; ready is judged at the falling edge
   task automatic push(input int n);
      int t;
      repeat (n)
      begin
         @(negedge clk);
         wr_data = 36'({$random(seed), $random(seed)});
         wr_valid = 1'b1;
         t = 0;
         while (wr_ready !== 1'b1 && t < 4000)
         begin
            @(negedge clk);
            t++;
         end
         guard(t);
         q.push_back(wr_data);
         hist.push_back(wr_data);
      end
      @(negedge clk);
      wr_valid = 1'b0;
   endtask : push

   // Read until the expected queue is empty, comparing in order
   task automatic pull_all;
      int t;
      int p;
      @(negedge clk);
      rd_enable = 1'b1;
      t = 0;
      p = 0;
      while (q.size() > 0 && t < 4000)
      begin
         @(posedge clk);
         #1;
         if (rd_valid === 1'b1)
         begin
            check("rd_data", rd_data,
                  (q[0] >> (p * part_w())) & 36'((37'h1 << part_w()) - 1));
            p++;
            if (p * part_w() >= mfx_pkg::LW_BITS)
            begin
               p = 0;
               void'(q.pop_front());
            end
         end
         t++;
      end
      guard(t);
      @(negedge clk);
      rd_enable = 1'b0;
      repeat (4) @(negedge clk);
   endtask : pull_all

   initial
   begin
      int t;
      int n;
      resetn = 1'b0;
      bus_size = mfx_pkg::MFX_SIZE_LONG;
      wr_data = 36'h0;
      wr_valid = 1'b0;
      rd_enable = 1'b0;
      replay_arm = 1'b1;
      replay_start = 1'b0;
      do_reset();
      // Replay: drain 12 words, rewind, read the same 12 again
      push(12);
      repeat (4) @(negedge clk);
      check("almost_empty_n", mfx_if_i.almost_empty_n, 36'h1);
      pull_all();
      check("almost_empty_n", mfx_if_i.almost_empty_n, 36'h0);
      replay_start = 1'b1;
      @(negedge clk);
      replay_start = 1'b0;
      t = 0;
      while (replay_done !== 1'b1 && t < 4000)
      begin
         @(posedge clk);
         #1;
         t++;
      end
      guard(t);
      repeat (4) @(negedge clk);
      check("empty_n", mfx_if_i.empty_n, 36'h1);
      check("almost_empty_n", mfx_if_i.almost_empty_n, 36'h1);
      q = hist;
      pull_all();
      replay_arm = 1'b0;
      $display("test replay done");
      // Each port B width, random count above the almost-empty offset
      foreach (sizes[i])
      begin
         bus_size = sizes[i];
         do_reset();
         n = 9 + ($unsigned($random(seed)) % 8);
         push(n);
         repeat (4) @(negedge clk);
         check("almost_empty_n", mfx_if_i.almost_empty_n, 36'h1);
         pull_all();
         check("almost_empty_n", mfx_if_i.almost_empty_n, 36'h0);
         $display("test size %0d done", i);
      end
      // Fill device and host buffer until the writer is refused
      bus_size = mfx_pkg::MFX_SIZE_LONG;
      do_reset();
      push(mfx_pkg::DEPTH_1K + 32);
      repeat (4) @(negedge clk);
      check("full_n", mfx_if_i.full_n, 36'h0);
      check("almost_full_n", mfx_if_i.almost_full_n, 36'h0);
      check("wr_ready", wr_ready, 36'h0);
      pull_all();
      check("almost_full_n", mfx_if_i.almost_full_n, 36'h1);
      check("empty_n", mfx_if_i.empty_n, 36'h0);
      $display("test fill done");
      print_verdict();
   end
endmodule : test_fifo_flag_mailbox_retransmit
